//--- include/t2mx_pkg.sv
package t2mx_pkg;
	// Frame geometry: four subframes, six blocks, 49 bits per block.
	localparam int LANES = 4;
	localparam logic [1:0] LAST_SF = 2'h3;
	localparam logic [2:0] LAST_BLK = 3'h5;
	localparam logic [5:0] LAST_POS = 6'h30;
	localparam logic [5:0] POS_OH = 6'h00;
	localparam logic [5:0] POS_ONE = 6'h01;
	// Overhead bit carried by each block.
	localparam logic [2:0] BLK_M = 3'h0;
	localparam logic [2:0] BLK_C1 = 3'h1;
	localparam logic [2:0] BLK_F1 = 3'h2;
	localparam logic [2:0] BLK_C2 = 3'h3;
	localparam logic [2:0] BLK_C3 = 3'h4;
	localparam logic [2:0] BLK_F2 = 3'h5;
	localparam logic [1:0] SF_FIRST = 2'h0;
	localparam logic [1:0] SF_ALARM = 2'h3;
	localparam logic [1:0] SF_AFTER_PATTERN = 2'h2;
	// Fixed overhead values.
	localparam logic M_FIRST_VAL = 1'b0;
	localparam logic M_NEXT_VAL = 1'b1;
	localparam logic F1_VAL = 1'b0;
	localparam logic F2_VAL = 1'b1;
	localparam logic [2:0] M_PATTERN = 3'h3;
	localparam logic STUFF_VAL = 1'b1;
	localparam logic IDLE_VAL = 1'b1;
	localparam logic [3:0] INV_LANES = 4'ha;
	// Tributary elastic store.
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] FIFO_FULL = 4'h8;
	localparam logic [3:0] STUFF_BELOW = 4'h4;
	localparam logic [3:0] FIFO_EMPTY = 4'h0;
	localparam logic [3:0] PTR_ONE = 4'h1;
	// Receive framer thresholds.
	localparam logic [3:0] SYNC_GOOD = 4'h8;
	localparam logic [1:0] SYNC_BAD = 2'h3;
	typedef enum logic [1:0] {FR_HUNT = 2'b00, FR_FLOCK = 2'b01, FR_SYNC = 2'b11} t2mx_frame_t;
endpackage : t2mx_pkg

//--- design/t2mx_m12_mux.sv
`timescale 1ns/1ns
// Contract
// [RL1] Four subframes rotate, first one leading
// [RL2] Six blocks of 49 bits, overhead first
// [RL3] Subframe bits: 0 first, 1 second, third
// [RL4] Frame bits: first 0, second 1
// [RL5] Last block holds the stuff opportunity
// [RL6] Stuff-control bits all equal; receiver majority-votes; the receiver here takes C1 = C2 = 1 with C3 = 0 as loopback and no stuff
// [RL7] Odd third control bit requests loopback
// [RL8] Alarm bit 0 while receiver unsynchronised
// [RL9] Tributaries interleaved one to four
// [RL10] Twelve bits per tributary per block
// [RL11] Tributaries two and four inverted
// [RL12] Tributaries mapped asynchronously, own rates
// [RL13] Subframe n stuffs tributary n
// [RL14] Overhead order M C1 F1 C2 C3 F2
// [RL15] Stuff decided per frame from fill
// [RL16] Receiver aligns, strips overhead, gaps output
module t2mx_m12_mux
	import t2mx_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Tributary bits entering the multiplexer.
	input wire logic [3:0] tribInValid,
	input wire logic [3:0] tribInBit,
	output logic [3:0] tribInReady,
	input wire logic [3:0] loopReqIn,
	// T2 stream out.
	output logic t2TxValid,
	output logic t2TxBit,
	input wire logic t2TxReady,
	// T2 stream in.
	input wire logic t2RxValid,
	input wire logic t2RxBit,
	output logic t2RxReady,
	// Tributary bits leaving the demultiplexer.
	output logic tribOutValid,
	output logic [1:0] tribOutLane,
	output logic tribOutBit,
	input wire logic tribOutReady,
	// Status.
	output logic rxInSync,
	output logic [3:0] loopDetect
);
	function automatic logic [10:0] advance(input logic [1:0] sf, input logic [2:0] blk,
		input logic [5:0] pos);
		logic [10:0] r;
		r = {sf, blk, pos + POS_ONE};
		if (pos == LAST_POS)
		begin
			r = {sf, blk + 3'h1, POS_OH};
			if (blk == LAST_BLK)
				r = {sf + 2'h1, 3'h0, POS_OH};
		end
		return r;
	endfunction : advance

	// Transmit side.
	logic txMem [LANES][FIFO_DEPTH];
	logic [3:0] wrPtr [LANES];
	logic [3:0] rdPtr [LANES];
	logic [3:0] fill [LANES];
	logic [1:0] txSf;
	logic [2:0] txBlk;
	logic [5:0] txPos;
	logic [3:0] stuffReq;
	logic txStep;
	logic next_txBit;
	logic [3:0] txPop;
	logic [5:0] txPosM1;
	logic [1:0] txLane;
	logic [3:0] storeWr;
	logic [3:0] storeRd;

	assign txStep = !t2TxValid || t2TxReady;
	assign txPosM1 = txPos - POS_ONE;
	assign txLane = txPosM1[1:0];
	assign storeWr = tribInValid & tribInReady;
	assign storeRd = txStep ? txPop : 4'h0;

	// Each tributary has its own store, so its rate need not match the T2 rate. [RL12]
	always_comb
	begin
		for (int l = 0; l < LANES; l++)
			fill[l] = wrPtr[l] - rdPtr[l];
	end

	always_comb
	begin
		next_txBit = IDLE_VAL;
		txPop = 4'h0;
		if (txPos == POS_OH)
		begin
			case (txBlk) // [RL14]
				BLK_M:
					if (txSf == SF_FIRST)
						next_txBit = M_FIRST_VAL; // [RL3]
					else if (txSf == SF_ALARM)
						next_txBit = rxInSync; // [RL8]
					else
						next_txBit = M_NEXT_VAL; // [RL3]
				BLK_C1, BLK_C2: next_txBit = stuffReq[txSf]; // [RL6]
				BLK_C3: next_txBit = stuffReq[txSf] ^ loopReqIn[txSf]; // [RL7]
				BLK_F1: next_txBit = F1_VAL; // [RL4]
				BLK_F2: next_txBit = F2_VAL; // [RL4]
				default: next_txBit = IDLE_VAL;
			endcase
		end
		else if (txBlk == LAST_BLK && txPos == {4'h0, txSf} + POS_ONE && stuffReq[txSf])
			next_txBit = STUFF_VAL; // [RL5] [RL13]
		else
		begin
			// An empty store sends an idle bit; the stuff decision should keep this rare.
			next_txBit = (fill[txLane] != FIFO_EMPTY) ? txMem[txLane][rdPtr[txLane][2:0]]
				: IDLE_VAL;
			next_txBit = next_txBit ^ INV_LANES[txLane]; // [RL9] [RL10] [RL11]
			txPop[txLane] = fill[txLane] != FIFO_EMPTY;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			txSf <= SF_FIRST;
			txBlk <= BLK_M;
			txPos <= POS_OH;
			t2TxValid <= 1'b0;
			t2TxBit <= IDLE_VAL;
		end
		else if (txStep)
		begin
			{txSf, txBlk, txPos} <= advance(txSf, txBlk, txPos); // [RL1] [RL2]
			t2TxValid <= 1'b1;
			t2TxBit <= next_txBit;
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			stuffReq <= 4'h0;
		else if (txStep && txSf == SF_FIRST && txBlk == BLK_M && txPos == POS_OH)
		begin
			for (int l = 0; l < LANES; l++)
				stuffReq[l] <= fill[l] < STUFF_BELOW; // [RL15]
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tribInReady <= 4'h0;
			for (int l = 0; l < LANES; l++)
			begin
				wrPtr[l] <= 4'h0;
				rdPtr[l] <= 4'h0;
				for (int d = 0; d < FIFO_DEPTH; d++)
					txMem[l][d] <= 1'b0;
			end
		end
		else
		begin
			for (int l = 0; l < LANES; l++)
			begin
				if (storeWr[l])
				begin
					txMem[l][wrPtr[l][2:0]] <= tribInBit[l];
					wrPtr[l] <= wrPtr[l] + PTR_ONE;
				end
				if (storeRd[l])
					rdPtr[l] <= rdPtr[l] + PTR_ONE;
				tribInReady[l] <= (fill[l] + {3'h0, storeWr[l]} - {3'h0, storeRd[l]}) < FIFO_FULL;
			end
		end
	end

	// Receive side.
	t2mx_frame_t frState;
	logic [1:0] rxSf;
	logic [2:0] rxBlk;
	logic [5:0] rxPos;
	logic [3:0] goodCnt;
	logic [1:0] badCnt;
	logic [1:0] mHist;
	logic [2:0] rxC;
	logic rxStuff;
	logic rxTake;
	logic fSlot;
	logic fOk;
	logic slip;
	logic push;
	logic pop;
	logic [5:0] rxPosM1;
	logic [1:0] pushLane;
	logic e1Valid;
	logic e1Bit;
	logic [1:0] e1Lane;
	logic [1:0] bufCnt;

	assign rxTake = t2RxValid && t2RxReady;
	assign fSlot = rxPos == POS_OH && (rxBlk == BLK_F1 || rxBlk == BLK_F2);
	assign fOk = t2RxBit == ((rxBlk == BLK_F1) ? F1_VAL : F2_VAL);
	assign slip = frState == FR_HUNT && fSlot && !fOk;
	assign rxPosM1 = rxPos - POS_ONE;
	assign pushLane = rxPosM1[1:0];
	assign push = rxTake && frState == FR_SYNC && rxPos != POS_OH
		&& !(rxBlk == LAST_BLK && rxStuff && rxPos == {4'h0, rxSf} + POS_ONE); // [RL16]
	assign pop = tribOutValid && tribOutReady;

	// While hunting, a bad frame bit holds the counter one bit, sliding the search.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rxSf <= SF_FIRST;
			rxBlk <= BLK_M;
			rxPos <= POS_OH;
		end
		else if (rxTake && !slip)
		begin
			{rxSf, rxBlk, rxPos} <= advance(rxSf, rxBlk, rxPos);
			if (frState == FR_FLOCK && rxPos == POS_OH && rxBlk == BLK_M
				&& {mHist, t2RxBit} == M_PATTERN)
				rxSf <= SF_AFTER_PATTERN; // [RL16]
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			frState <= FR_HUNT;
			goodCnt <= 4'h0;
			badCnt <= 2'h0;
			mHist <= 2'h0;
			rxInSync <= 1'b0;
		end
		else if (rxTake)
		begin
			if (rxPos == POS_OH && rxBlk == BLK_M)
				mHist <= {mHist[0], t2RxBit};
			case (frState)
				FR_HUNT:
					if (fSlot)
					begin
						goodCnt <= fOk ? goodCnt + 4'h1 : 4'h0;
						if (fOk && goodCnt + 4'h1 == SYNC_GOOD)
							frState <= FR_FLOCK;
					end
				FR_FLOCK:
					if (fSlot && !fOk)
					begin
						frState <= FR_HUNT;
						goodCnt <= 4'h0;
					end
					else if (rxPos == POS_OH && rxBlk == BLK_M && {mHist, t2RxBit} == M_PATTERN)
					begin
						frState <= FR_SYNC;
						badCnt <= 2'h0;
						rxInSync <= 1'b1;
					end
				FR_SYNC:
					if (fSlot)
					begin
						badCnt <= fOk ? 2'h0 : badCnt + 2'h1;
						if (!fOk && badCnt + 2'h1 == SYNC_BAD)
						begin
							frState <= FR_HUNT;
							goodCnt <= 4'h0;
							rxInSync <= 1'b0;
						end
					end
				default: frState <= FR_HUNT;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rxC <= 3'h0;
			rxStuff <= 1'b0;
			loopDetect <= 4'h0;
		end
		else if (rxTake && rxPos == POS_OH && frState == FR_SYNC)
		begin
			case (rxBlk)
				BLK_C1: rxC[0] <= t2RxBit;
				BLK_C2: rxC[1] <= t2RxBit;
				BLK_C3: rxC[2] <= t2RxBit;
				BLK_F2:
				begin
					if (rxC[0] == rxC[1] && rxC[2] != rxC[0])
					begin
						rxStuff <= 1'b0; // [RL7]
						loopDetect[rxSf] <= 1'b1;
					end
					else
					begin
						rxStuff <= (rxC[0] & rxC[1]) | (rxC[0] & rxC[2]) | (rxC[1] & rxC[2]); // [RL6]
						loopDetect[rxSf] <= 1'b0;
					end
				end
				default: rxStuff <= rxStuff;
			endcase
		end
	end

	// Two-entry buffer: ready is withdrawn a cycle early so no pushed bit is lost.
	always_comb
	begin
		bufCnt = {1'b0, tribOutValid} + {1'b0, e1Valid};
		bufCnt = bufCnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tribOutValid <= 1'b0;
			tribOutLane <= 2'h0;
			tribOutBit <= 1'b0;
			e1Valid <= 1'b0;
			e1Lane <= 2'h0;
			e1Bit <= 1'b0;
			t2RxReady <= 1'b0;
		end
		else
		begin
			t2RxReady <= bufCnt != 2'h2;
			if (pop)
			begin
				tribOutValid <= e1Valid || push;
				tribOutLane <= e1Valid ? e1Lane : pushLane;
				tribOutBit <= e1Valid ? e1Bit : t2RxBit ^ INV_LANES[pushLane]; // [RL11]
				e1Valid <= e1Valid && push;
				e1Lane <= pushLane;
				e1Bit <= t2RxBit ^ INV_LANES[pushLane];
			end
			else if (push && !tribOutValid)
			begin
				tribOutValid <= 1'b1;
				tribOutLane <= pushLane;
				tribOutBit <= t2RxBit ^ INV_LANES[pushLane];
			end
			else if (push)
			begin
				e1Valid <= 1'b1;
				e1Lane <= pushLane;
				e1Bit <= t2RxBit ^ INV_LANES[pushLane];
			end
		end
	end
endmodule : t2mx_m12_mux

//--- verif/t2mx_m12_sva.sv
`timescale 1ns/1ns
module t2mx_m12_sva
	import t2mx_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Watched ports.
	input wire logic [3:0] tribInValid,
	input wire logic [3:0] tribInReady,
	input wire logic t2TxValid,
	input wire logic t2TxBit,
	input wire logic t2TxReady,
	input wire logic t2RxReady,
	input wire logic tribOutValid,
	input wire logic [1:0] tribOutLane,
	input wire logic tribOutBit,
	input wire logic tribOutReady,
	input wire logic rxInSync,
	input wire logic [3:0] loopDetect
);
	int pos;
	logic oh;
	logic [2:0] blk;
	logic [1:0] sf;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// Frame position of the offered bit; M of the first subframe follows reset.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			pos <= 0;
		else if (t2TxValid && t2TxReady)
			pos <= (pos + 1) % 1176;
	end
	assign oh = t2TxValid && (pos % 49 == 0);
	assign blk = 3'(pos / 49 % 6);
	assign sf = 2'(pos / 294);
	a_m_first_zero: assert property (oh && blk == BLK_M && sf == SF_FIRST |-> !t2TxBit)
		else $error("first M bit not 0");
	a_m_next_one: assert property (oh && blk == BLK_M && sf inside {2'h1, 2'h2} |-> t2TxBit)
		else $error("second or third M bit not 1");
	a_f1_zero: assert property (oh && blk == BLK_F1 |-> !t2TxBit)
		else $error("F1 not 0");
	a_f2_one: assert property (oh && blk == BLK_F2 |-> t2TxBit)
		else $error("F2 not 1");
	a_tx_held: assert property (t2TxValid && !t2TxReady |=> t2TxValid && $stable(t2TxBit))
		else $error("T2 bit dropped before taken");
	a_out_held: assert property (tribOutValid && !tribOutReady |=>
		tribOutValid && $stable({tribOutLane, tribOutBit})) else $error("output bit not held");
	a_no_hunt_data: assert property (!rxInSync && !tribOutValid |=> !tribOutValid)
		else $error("bit delivered out of sync");
	a_ready_take: assert property ($fell(tribInReady[0]) |-> $past(tribInValid[0]))
		else $error("store filled with no bit taken");
	a_loop_sync: assert property ($rose(|loopDetect) |-> $past(rxInSync))
		else $error("loopback seen out of sync");
	// An empty output stage must always leave room for the next T2 bit.
	a_rx_room: assert property (t2TxValid && !tribOutValid |=> t2RxReady)
		else $error("T2 input refused with output stage empty");
	c_sync: cover property ($rose(rxInSync));
	c_loop: cover property ($rose(|loopDetect));
	c_stall: cover property (tribOutValid && !tribOutReady);
endmodule : t2mx_m12_sva
bind t2mx_m12_mux t2mx_m12_sva i_t2mx_m12_sva (.*);

//--- verif/t2mx_far_end.sv
`timescale 1ns/1ns
module t2mx_far_end
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Behaviour chosen by the bench.
	input wire logic slow,
	input wire logic flip,
	// T2 stream looped from transmit back to receive.
	input wire logic t2TxValid,
	input wire logic t2TxBit,
	output logic t2TxReady,
	output logic t2RxValid,
	output logic t2RxBit,
	input wire logic t2RxReady
);
	logic go;
	// Take a bit only when the last one is gone, so a receive stall loses nothing.
	assign t2TxReady = go && (!t2RxValid || t2RxReady);
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			go <= 1'h0;
			t2RxValid <= 1'h0;
			t2RxBit <= 1'h0;
		end
		else
		begin
			go <= !slow || !go;
			if (t2TxValid && t2TxReady)
			begin
				t2RxValid <= 1'h1;
				t2RxBit <= t2TxBit ^ flip;
			end
			else if (t2RxValid && t2RxReady)
			begin
				t2RxValid <= 1'h0;
				// A released line must not keep showing the last bit.
				t2RxBit <= ~t2RxBit;
			end
		end
	end
endmodule : t2mx_far_end

//--- verif/t2mx_m12_mux_tb_top.sv
`timescale 1ns/1ns
module t2mx_m12_mux_tb_top
	import t2mx_pkg::*;
;
	logic mclk, rst_b, t2TxValid, t2TxBit, t2TxReady, t2RxValid, t2RxBit, t2RxReady;
	logic tribOutValid, tribOutBit, tribOutReady, rxInSync, slow, flip, syncAtLoad;
	logic [3:0] tribInValid, tribInBit, tribInReady, loopReqIn, loopDetect, cBits, stuffSeen;
	logic [1:0] tribOutLane;
	int n_mismatch, samples_checked, cyc, pos, k, ln;
	t2mx_m12_mux i_t2mx_m12_mux (.*);
	t2mx_far_end i_t2mx_far_end (.*);
	initial
	begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	task automatic check(input logic seen, input logic exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %0t: saw %b want %b", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	// Each lane sends a constant, so every wire bit has a known value.
	always @(posedge mclk)
	begin
		if (!rst_b)
			pos <= 0;
		else if (t2TxValid && t2TxReady)
		begin
			k = pos % 49;
			ln = (k + 3) % 4;
			// A signalled stuff slot carries the stuff value instead of lane data.
			if (pos % 294 / 49 == 5 && k == pos / 294 + 1 && cBits[0])
				check(t2TxBit, STUFF_VAL);
			else if (k != 0)
				check(t2TxBit, tribInBit[ln] ^ INV_LANES[ln]);
			else
				case (pos % 294 / 49)
					0: if (pos / 294 == 3) check(t2TxBit, syncAtLoad);
					1: cBits[0] = t2TxBit;
					3: cBits[1] = t2TxBit;
					4: cBits[2] = t2TxBit;
					5:
					begin
						check(cBits[1], cBits[0]);
						check(cBits[2], cBits[0] ^ loopReqIn[pos / 294]);
						stuffSeen[pos / 294] = cBits[0];
					end
					default: ;
				endcase
			syncAtLoad <= rxInSync;
			pos <= (pos + 1) % 1176;
		end
	end
	always @(posedge mclk)
		if (rst_b && !flip && tribOutValid && tribOutReady)
			check(tribOutBit, tribInBit[tribOutLane]);
	task automatic wait_sync(input logic want);
		for (int i = 0; i < 30000 && rxInSync !== want; i++)
			@(negedge mclk);
		check(rxInSync, want);
	endtask : wait_sync
	task automatic run_stall();
		@(posedge mclk);
		slow <= 1'h1;
		tribOutReady <= 1'h0;
		repeat (40) @(posedge mclk);
		tribOutReady <= 1'h1;
		repeat (3000) @(negedge mclk);
		check(rxInSync, 1'h1);
		@(posedge mclk);
		slow <= 1'h0;
	endtask : run_stall
	task automatic run_stuff();
		@(posedge mclk);
		tribInValid <= 4'he;
		repeat (3000) @(negedge mclk);
		check(stuffSeen === 4'h1, 1'h1);
		@(posedge mclk);
		tribInValid <= 4'hf;
	endtask : run_stuff
	// Change the request away from subframe 1 so a C3 in flight is never split.
	task automatic run_loop(input logic [3:0] req);
		while (pos != 600)
			@(posedge mclk);
		loopReqIn <= req;
		repeat (2500) @(negedge mclk);
		check(loopDetect === req, 1'h1);
	endtask : run_loop
	initial
	begin
		rst_b = 1'h0;
		tribInValid = 4'h0;
		tribInBit = 4'h3;
		tribOutReady = 1'h1;
		loopReqIn = 4'h0;
		slow = 1'h0;
		flip = 1'h0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'h1;
		tribInValid <= 4'hf;
		wait_sync(1'h1);
		run_stall();
		run_stuff();
		run_loop(4'h2);
		run_loop(4'h0);
		@(posedge mclk);
		flip <= 1'h1;
		wait_sync(1'h0);
		repeat (1300) @(negedge mclk);
		complete_run();
	end
endmodule : t2mx_m12_mux_tb_top
